// File: gpio_consts.svh
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses in data memory
// ----------------------------------------------------------------
`define ADDR_L_DATA 8'hD0
`define ADDR_L_CFG 8'hD1
`define ADDR_L_PIN 8'hD2
`define ADDR_G_DATA 8'hD4
`define ADDR_G_CFG 8'hD5
`define ADDR_G_PIN 8'hD6
`define ADDR_M_DATA 8'hD8
`define ADDR_M_CFG 8'hD9
`define ADDR_M_PIN 8'hDA
`define ADDR_L_WAKE_EN 8'hE0
`define ADDR_M_WAKE_EN 8'hE1
`define ADDR_L_WAKE_PEND 8'hE2
`define ADDR_M_WAKE_PEND 8'hE3
`define ADDR_M_ALT_WAKE 8'hE4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define G_HALT_BIT 7
`define G_IDLE_BIT 6
`define G_CLOCK_OUTPUT_DELAY_SELECT_BIT 7
`define G_ALT_PHASE_BIT 6
`define G_IO_MASK 8'h3F
`define G_SERIAL_OUT_BIT 4
`define G_SERIAL_CLK_BIT 5
`define G_SERIAL_IN_BIT 6
`define G_TIMER1_IO_BIT 3
`define G_TIMER1_CAP_BIT 2
`define G_SUPERVISOR_BIT 1
`define G_EXT_IRQ_BIT 0
`define G_OSC_OUT_BIT 7
`define L_USART_RX_BIT 3
`define L_USART_TX_BIT 2
`define L_USART_CLK_BIT 1
`define M_TIMER2_B_BIT 5
`define M_CAN_WAKE_BIT 7
`define M_SPI_MASK 8'h0F

// ----------------------------------------------------------------
// Reset values and SPI pin directions (bit0 MISO .. bit3 SS)
// ----------------------------------------------------------------
`define PORT_RESET 8'h00
`define SPI_OE_MASTER 4'hE
`define SPI_OE_SLAVE 4'h1

`endif

// File: gpio_pkg.sv
package gpio_pkg;

  typedef logic [7:0] port_byte_type;

  // Order follows {config bit, data bit}
  typedef enum logic [1:0] {
    MODE_HIZ,
    MODE_PULLUP,
    MODE_DRIVE_LOW,
    MODE_DRIVE_HIGH
  } pad_mode_type;

endpackage

// File: pad_ctrl_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pad_ctrl_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] cfg;
  logic [WIDTH-1:0] dat;
  logic [WIDTH-1:0] alt_mask;
  logic [WIDTH-1:0] alt_out;
  logic [WIDTH-1:0] alt_oe;
  logic [WIDTH-1:0] force_in;
  logic [WIDTH-1:0] pin_out;
  logic [WIDTH-1:0] pin_oe;
  logic [WIDTH-1:0] pull_up;

  modport ctrl (
    output cfg, dat, alt_mask, alt_out, alt_oe, force_in,
    input pin_out, pin_oe, pull_up
  );
  modport pad (
    input cfg, dat, alt_mask, alt_out, alt_oe, force_in,
    output pin_out, pin_oe, pull_up
  );
endinterface

`default_nettype wire

// File: pad_mux.sv
`timescale 1ns/10ps
`default_nettype none

module pad_mux
  import gpio_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  pad_ctrl_if.pad bus
);

  logic [WIDTH-1:0] next_out;
  logic [WIDTH-1:0] next_oe;
  logic [WIDTH-1:0] next_pull;
  pad_mode_type mode;

  always_comb begin
    next_out = '0;
    next_oe = '0;
    next_pull = '0;
    mode = MODE_HIZ;
    for (int i = 0; i < WIDTH; i++) begin
      mode = pad_mode_type'({bus.cfg[i], bus.dat[i]});
      if (bus.force_in[i]) begin
        next_oe[i] = 1'b0;
      end else if (bus.alt_mask[i]) begin
        // Peripheral owns the pin; its own bits are ignored
        next_out[i] = bus.alt_out[i];
        next_oe[i] = bus.alt_oe[i];
      end else begin
        case (mode)
          MODE_PULLUP: next_pull[i] = 1'b1;
          MODE_DRIVE_LOW: next_oe[i] = 1'b1;
          MODE_DRIVE_HIGH: begin
            next_oe[i] = 1'b1;
            next_out[i] = 1'b1;
          end
          default: next_oe[i] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus.pin_out <= '0;
      bus.pin_oe <= '0;
      bus.pull_up <= '0;
    end else begin
      bus.pin_out <= next_out;
      bus.pin_oe <= next_oe;
      bus.pull_up <= next_pull;
    end
  end

endmodule

`default_nettype wire

// File: wake_unit.sv
`timescale 1ns/10ps
`default_nettype none

module wake_unit #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] alt_sel,
  input wire logic [WIDTH-1:0] alt_src,
  input wire logic [WIDTH-1:0] enable,
  input wire logic [WIDTH-1:0] clear,
  output logic [WIDTH-1:0] pending
);

  logic [WIDTH-1:0] source;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] rise;

  assign source = (level & ~alt_sel) | (alt_src & alt_sel);
  assign rise = source & ~prev;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev <= '0;
    end else begin
      prev <= source;
    end
  end

  // A new edge in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~clear) | (rise & enable);
    end
  end

endmodule

`default_nettype wire

// File: gpio_port_config_wakeup.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"

// Functional notes
// (RULE1) Config and data bits pick pin mode
// (RULE2) Each port: config, data, read-only pin address
// (RULE3) Every bit independently input, output or Hi-Z
// (RULE4) All L and M pins feed wakeup
// (RULE5) Both wakeup ports share one interrupt
// (RULE6) G0-G5 I/O, G6 input, G7 clock out
// (RULE7) Special port data bits 6,7 read zero
// (RULE8) Writing one to data bit 7 halts
// (RULE9) Writing one to data bit 6 idles
// (RULE10) Config bit 6 phase, bit 7 delay
// (RULE11) Alternate function overrides pin config and data
// (RULE12) Alternate wake source masks pin, still readable
// (RULE13) SPI enabled sets its pin directions
// (RULE14) SPI disabled frees pins to software
// (RULE15) Pin M7 alternate wake carries CAN wake
// (RULE16) USART on L3, L2, L1; wakeup kept
// (RULE17) Special port serial, timer, supervisor, irq pins
// (RULE18) M5 alternate second timer B pin
// (RULE19) HALT/IDLE writes become one-cycle requests
module gpio_port_config_wakeup
  import gpio_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic [7:0] PORT_G_IN,
  output logic [7:0] PORT_G_OUT,
  output logic [7:0] PORT_G_OE_OUT,
  output logic [7:0] PORT_G_PULLUP_OUT,
  input wire logic [7:0] PORT_L_IN,
  output logic [7:0] PORT_L_OUT,
  output logic [7:0] PORT_L_OE_OUT,
  output logic [7:0] PORT_L_PULLUP_OUT,
  input wire logic [7:0] PORT_M_IN,
  output logic [7:0] PORT_M_OUT,
  output logic [7:0] PORT_M_OE_OUT,
  output logic [7:0] PORT_M_PULLUP_OUT,
  input wire logic OSC_CLK_IN,
  input wire logic SERIAL_DATA_OUT_EN_IN,
  input wire logic SERIAL_DATA_OUT_VAL_IN,
  input wire logic SERIAL_CLOCK_LINE_EN_IN,
  input wire logic SERIAL_CLOCK_LINE_VAL_IN,
  input wire logic TIMER1_IO_PIN_EN_IN,
  input wire logic TIMER1_IO_PIN_VAL_IN,
  input wire logic SUPERVISOR_EN_IN,
  input wire logic SUPERVISOR_VAL_IN,
  input wire logic USART_TRANSMIT_PIN_EN_IN,
  input wire logic USART_TRANSMIT_PIN_VAL_IN,
  input wire logic USART_CLOCK_PIN_EN_IN,
  input wire logic USART_CLOCK_PIN_VAL_IN,
  input wire logic SPI_EN_IN,
  input wire logic SPI_MASTER_IN,
  input wire logic [3:0] SPI_DRIVE_VAL_IN,
  input wire logic TIMER2_B_PIN_EN_IN,
  input wire logic TIMER2_B_PIN_VAL_IN,
  input wire logic CAN_WAKE_IN,
  output logic HALT_REQ_OUT,
  output logic IDLE_REQ_OUT,
  output logic SERIAL_ALT_PHASE_OUT,
  output logic CLOCK_OUTPUT_DELAY_SELECT_OUT,
  output logic MULTI_INPUT_WAKEUP_IRQ_OUT,
  output logic EXTERNAL_IRQ_PIN_OUT,
  output logic TIMER1_CAPTURE_OUT,
  output logic SERIAL_DATA_IN_OUT,
  output logic TIMER1_IO_PIN_OUT,
  output logic USART_RECEIVE_PIN_OUT,
  output logic USART_CLOCK_PIN_OUT,
  output logic [3:0] SPI_PIN_LEVEL_OUT,
  output logic TIMER2_B_PIN_OUT
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  port_byte_type port_g_cfg;
  port_byte_type port_g_data;
  port_byte_type port_l_cfg;
  port_byte_type port_l_data;
  port_byte_type port_m_cfg;
  port_byte_type port_m_data;
  port_byte_type l_wake_en;
  port_byte_type m_wake_en;
  port_byte_type m_alt_wake;
  port_byte_type l_wake_pend;
  port_byte_type m_wake_pend;
  port_byte_type l_wake_clear;
  port_byte_type m_wake_clear;
  port_byte_type next_rdata;
  logic osc_sample;

  pad_ctrl_if #(.WIDTH(8)) g_bus ();
  pad_ctrl_if #(.WIDTH(8)) l_bus ();
  pad_ctrl_if #(.WIDTH(8)) m_bus ();

  // ----------------------------------------------------------------
  // Configuration and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      {port_g_cfg, port_g_data, port_l_cfg} <= {3{`PORT_RESET}};
      {port_l_data, port_m_cfg, port_m_data} <= {3{`PORT_RESET}};
    end else if (WR_EN_IN) begin
      case (ADDR_IN)
        `ADDR_G_CFG: port_g_cfg <= WDATA_IN; // [RULE2] [RULE3]
        // Bits 6 and 7 are commands, never stored
        `ADDR_G_DATA: port_g_data <= WDATA_IN & `G_IO_MASK; // [RULE7]
        `ADDR_L_CFG: port_l_cfg <= WDATA_IN; // [RULE2] [RULE3]
        `ADDR_L_DATA: port_l_data <= WDATA_IN; // [RULE2] [RULE3]
        `ADDR_M_CFG: port_m_cfg <= WDATA_IN; // [RULE2] [RULE3]
        `ADDR_M_DATA: port_m_data <= WDATA_IN; // [RULE2] [RULE3]
        default: port_g_cfg <= port_g_cfg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power-mode requests
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      {HALT_REQ_OUT, IDLE_REQ_OUT} <= 2'h0;
    end else begin
      HALT_REQ_OUT <= WR_EN_IN && ADDR_IN == `ADDR_G_DATA &&
                      WDATA_IN[`G_HALT_BIT]; // [RULE8] [RULE19]
      IDLE_REQ_OUT <= WR_EN_IN && ADDR_IN == `ADDR_G_DATA &&
                      WDATA_IN[`G_IDLE_BIT]; // [RULE9] [RULE19]
    end
  end

  // ----------------------------------------------------------------
  // Special-port control bits
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      SERIAL_ALT_PHASE_OUT <= 1'b0;
      CLOCK_OUTPUT_DELAY_SELECT_OUT <= 1'b0;
      osc_sample <= 1'b0;
    end else begin
      SERIAL_ALT_PHASE_OUT <= port_g_cfg[`G_ALT_PHASE_BIT]; // [RULE10]
      CLOCK_OUTPUT_DELAY_SELECT_OUT <= port_g_cfg[`G_CLOCK_OUTPUT_DELAY_SELECT_BIT]; // [RULE10]
      osc_sample <= OSC_CLK_IN;
    end
  end

  // ----------------------------------------------------------------
  // Wakeup registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      {l_wake_en, m_wake_en, m_alt_wake} <= {3{`PORT_RESET}};
    end else if (WR_EN_IN) begin
      case (ADDR_IN)
        `ADDR_L_WAKE_EN: l_wake_en <= WDATA_IN;
        `ADDR_M_WAKE_EN: m_wake_en <= WDATA_IN;
        `ADDR_M_ALT_WAKE: m_alt_wake <= WDATA_IN;
        default: l_wake_en <= l_wake_en;
      endcase
    end
  end

  // Pending bits clear by writing ones
  assign l_wake_clear = (WR_EN_IN && ADDR_IN == `ADDR_L_WAKE_PEND) ?
                        WDATA_IN : 8'h00;
  assign m_wake_clear = (WR_EN_IN && ADDR_IN == `ADDR_M_WAKE_PEND) ?
                        WDATA_IN : 8'h00;

  // L pins keep wakeup under USART use
  wake_unit #(.WIDTH(8)) l_wake (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .level(PORT_L_IN), // [RULE4] [RULE16]
    .alt_sel(8'h00),
    .alt_src(8'h00),
    .enable(l_wake_en),
    .clear(l_wake_clear),
    .pending(l_wake_pend)
  );

  // Only M7 has an alternate source; others just mask
  wake_unit #(.WIDTH(8)) m_wake (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .level(PORT_M_IN), // [RULE4]
    .alt_sel(m_alt_wake), // [RULE12]
    .alt_src({CAN_WAKE_IN, 7'h00}), // [RULE15]
    .enable(m_wake_en),
    .clear(m_wake_clear),
    .pending(m_wake_pend)
  );

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      MULTI_INPUT_WAKEUP_IRQ_OUT <= 1'b0;
    end else begin
      MULTI_INPUT_WAKEUP_IRQ_OUT <= |{l_wake_pend, m_wake_pend}; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // Port G pad control
  // ----------------------------------------------------------------
  always_comb begin
    g_bus.cfg = port_g_cfg & `G_IO_MASK; // [RULE6]
    g_bus.dat = port_g_data;
    g_bus.force_in = 8'h00;
    g_bus.force_in[`G_SERIAL_IN_BIT] = 1'b1; // [RULE6]
    g_bus.alt_mask = 8'h00;
    g_bus.alt_out = 8'h00;
    g_bus.alt_oe = 8'hFF;
    g_bus.alt_mask[`G_OSC_OUT_BIT] = 1'b1; // [RULE6]
    g_bus.alt_out[`G_OSC_OUT_BIT] = osc_sample;
    g_bus.alt_mask[`G_SERIAL_OUT_BIT] = SERIAL_DATA_OUT_EN_IN; // [RULE17]
    g_bus.alt_out[`G_SERIAL_OUT_BIT] = SERIAL_DATA_OUT_VAL_IN;
    g_bus.alt_mask[`G_SERIAL_CLK_BIT] = SERIAL_CLOCK_LINE_EN_IN; // [RULE17]
    g_bus.alt_out[`G_SERIAL_CLK_BIT] = SERIAL_CLOCK_LINE_VAL_IN;
    g_bus.alt_mask[`G_TIMER1_IO_BIT] = TIMER1_IO_PIN_EN_IN; // [RULE17]
    g_bus.alt_out[`G_TIMER1_IO_BIT] = TIMER1_IO_PIN_VAL_IN;
    g_bus.alt_mask[`G_SUPERVISOR_BIT] = SUPERVISOR_EN_IN; // [RULE17]
    g_bus.alt_out[`G_SUPERVISOR_BIT] = SUPERVISOR_VAL_IN;
  end

  // ----------------------------------------------------------------
  // Port L pad control
  // ----------------------------------------------------------------
  always_comb begin
    l_bus.cfg = port_l_cfg;
    l_bus.dat = port_l_data;
    l_bus.force_in = 8'h00;
    l_bus.alt_mask = 8'h00;
    l_bus.alt_out = 8'h00;
    l_bus.alt_oe = 8'hFF;
    l_bus.alt_mask[`L_USART_TX_BIT] = USART_TRANSMIT_PIN_EN_IN; // [RULE16]
    l_bus.alt_out[`L_USART_TX_BIT] = USART_TRANSMIT_PIN_VAL_IN;
    l_bus.alt_mask[`L_USART_CLK_BIT] = USART_CLOCK_PIN_EN_IN; // [RULE16]
    l_bus.alt_out[`L_USART_CLK_BIT] = USART_CLOCK_PIN_VAL_IN;
  end

  // ----------------------------------------------------------------
  // Port M pad control
  // ----------------------------------------------------------------
  always_comb begin
    m_bus.cfg = port_m_cfg;
    m_bus.dat = port_m_data;
    m_bus.force_in = 8'h00;
    m_bus.alt_mask = 8'h00;
    m_bus.alt_out = 8'h00;
    m_bus.alt_oe = 8'hFF;
    if (SPI_EN_IN) begin
      m_bus.alt_mask = `M_SPI_MASK; // [RULE11] [RULE13]
      m_bus.alt_out[3:0] = SPI_DRIVE_VAL_IN;
      m_bus.alt_oe[3:0] = SPI_MASTER_IN ? `SPI_OE_MASTER :
                          `SPI_OE_SLAVE; // [RULE13]
    end
    // SPI off leaves the mask clear: software bits rule [RULE14]
    m_bus.alt_mask[`M_TIMER2_B_BIT] = TIMER2_B_PIN_EN_IN; // [RULE18]
    m_bus.alt_out[`M_TIMER2_B_BIT] = TIMER2_B_PIN_VAL_IN;
  end

  pad_mux #(.WIDTH(8)) g_pads (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .bus(g_bus) // [RULE1] [RULE11]
  );

  pad_mux #(.WIDTH(8)) l_pads (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .bus(l_bus) // [RULE1] [RULE11]
  );

  pad_mux #(.WIDTH(8)) m_pads (
    .clk(CLK_IN),
    .rst_b(RST_B_IN),
    .bus(m_bus) // [RULE1] [RULE11]
  );

  assign PORT_G_OUT = g_bus.pin_out;
  assign PORT_G_OE_OUT = g_bus.pin_oe;
  assign PORT_G_PULLUP_OUT = g_bus.pull_up;
  assign PORT_L_OUT = l_bus.pin_out;
  assign PORT_L_OE_OUT = l_bus.pin_oe;
  assign PORT_L_PULLUP_OUT = l_bus.pull_up;
  assign PORT_M_OUT = m_bus.pin_out;
  assign PORT_M_OE_OUT = m_bus.pin_oe;
  assign PORT_M_PULLUP_OUT = m_bus.pull_up;

  // ----------------------------------------------------------------
  // Pin levels handed to peripherals
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      {EXTERNAL_IRQ_PIN_OUT, TIMER1_CAPTURE_OUT, SERIAL_DATA_IN_OUT} <= 3'h0;
      {TIMER1_IO_PIN_OUT, USART_RECEIVE_PIN_OUT, USART_CLOCK_PIN_OUT} <= 3'h0;
      {SPI_PIN_LEVEL_OUT, TIMER2_B_PIN_OUT} <= 5'h00;
    end else begin
      EXTERNAL_IRQ_PIN_OUT <= PORT_G_IN[`G_EXT_IRQ_BIT]; // [RULE17]
      TIMER1_CAPTURE_OUT <= PORT_G_IN[`G_TIMER1_CAP_BIT]; // [RULE17]
      SERIAL_DATA_IN_OUT <= PORT_G_IN[`G_SERIAL_IN_BIT]; // [RULE17]
      TIMER1_IO_PIN_OUT <= PORT_G_IN[`G_TIMER1_IO_BIT]; // [RULE17]
      USART_RECEIVE_PIN_OUT <= PORT_L_IN[`L_USART_RX_BIT]; // [RULE16]
      USART_CLOCK_PIN_OUT <= PORT_L_IN[`L_USART_CLK_BIT]; // [RULE16]
      SPI_PIN_LEVEL_OUT <= PORT_M_IN[3:0]; // [RULE13]
      TIMER2_B_PIN_OUT <= PORT_M_IN[`M_TIMER2_B_BIT]; // [RULE18]
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Pin addresses return the raw levels, alternate use or not
  always_comb begin
    case (ADDR_IN)
      `ADDR_G_CFG: next_rdata = port_g_cfg;
      `ADDR_G_DATA: next_rdata = port_g_data & `G_IO_MASK; // [RULE7]
      `ADDR_G_PIN: next_rdata = PORT_G_IN; // [RULE2]
      `ADDR_L_CFG: next_rdata = port_l_cfg;
      `ADDR_L_DATA: next_rdata = port_l_data;
      `ADDR_L_PIN: next_rdata = PORT_L_IN; // [RULE2]
      `ADDR_M_CFG: next_rdata = port_m_cfg;
      `ADDR_M_DATA: next_rdata = port_m_data;
      `ADDR_M_PIN: next_rdata = PORT_M_IN; // [RULE2] [RULE12]
      `ADDR_L_WAKE_EN: next_rdata = l_wake_en;
      `ADDR_M_WAKE_EN: next_rdata = m_wake_en;
      `ADDR_L_WAKE_PEND: next_rdata = l_wake_pend;
      `ADDR_M_WAKE_PEND: next_rdata = m_wake_pend;
      `ADDR_M_ALT_WAKE: next_rdata = m_alt_wake;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_EN_IN) begin
      RDATA_OUT <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// File: pin_board.sv
`timescale 1ns/10ps
`default_nettype none

module pin_board (
  input wire logic [7:0] oe_in,
  input wire logic [7:0] drive_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] level_out
);
  // Board drives every pin the device leaves alone, so nothing floats
  always_comb begin
    level_out = (oe_in & drive_in) | (~oe_in & ext_val_in);
  end
endmodule

`default_nettype wire

// File: gpio_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"

module gpio_port_monitor (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [7:0] PORT_G_IN,
  input wire logic [7:0] PORT_G_OUT,
  input wire logic [7:0] PORT_G_OE_OUT,
  input wire logic OSC_CLK_IN,
  input wire logic HALT_REQ_OUT,
  input wire logic IDLE_REQ_OUT,
  input wire logic SERIAL_ALT_PHASE_OUT,
  input wire logic CLOCK_OUTPUT_DELAY_SELECT_OUT,
  input wire logic EXTERNAL_IRQ_PIN_OUT
);
  // Edges since reset release, so $past never looks into reset
  logic [1:0] up;

  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  wire logic g_wr = WR_EN_IN && ADDR_IN == `ADDR_G_DATA;

  sequence g_data_wr;
    g_wr;
  endsequence
  sequence g_cfg_wr;
    WR_EN_IN && ADDR_IN == `ADDR_G_CFG;
  endsequence

  chk_halt_pulse:
    assert property (g_data_wr ##0 WDATA_IN[7] |=> HALT_REQ_OUT)
    else $error("halt request missing");
  chk_halt_once:
    assert property (up != 2'h0 && HALT_REQ_OUT |->
      $past(g_wr && WDATA_IN[7]))
    else $error("halt request without a write");
  chk_idle_req:
    assert property (up != 2'h0 |-> IDLE_REQ_OUT ==
      $past(g_wr && WDATA_IN[6]))
    else $error("idle request wrong");
  chk_alt_phase:
    assert property (g_cfg_wr |->
      ##2 SERIAL_ALT_PHASE_OUT == $past(WDATA_IN[6], 2))
    else $error("serial phase select wrong");
  chk_delay_select:
    assert property (g_cfg_wr ##2 1'b1 |->
      CLOCK_OUTPUT_DELAY_SELECT_OUT == $past(WDATA_IN[7], 2))
    else $error("clock delay select wrong");
  chk_g_read_zero:
    assert property (RD_EN_IN && ADDR_IN == `ADDR_G_DATA |=>
      RDATA_OUT[7:6] == 2'h0)
    else $error("special data bits read nonzero");
  chk_rdata_hold:
    assert property (!RD_EN_IN |=> $stable(RDATA_OUT))
    else $error("read data changed without a read");
  chk_osc_pin:
    assert property (up == 2'h3 |-> PORT_G_OE_OUT[7] &&
      PORT_G_OUT[7] == $past(OSC_CLK_IN, 2))
    else $error("clock output pin wrong");
  chk_g6_input:
    assert property (!PORT_G_OE_OUT[6])
    else $error("input only pin driven");
  chk_irq_echo:
    assert property (up != 2'h0 |->
      EXTERNAL_IRQ_PIN_OUT == $past(PORT_G_IN[0]))
    else $error("external irq level wrong");
endmodule

bind gpio_port_config_wakeup gpio_port_monitor mon_u (.*);

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"

module tb_top;
  localparam logic [7:0] a_cfg[3] = '{`ADDR_G_CFG, `ADDR_L_CFG, `ADDR_M_CFG};
  localparam logic [7:0] a_dat[3] = '{`ADDR_G_DATA, `ADDR_L_DATA, `ADDR_M_DATA};
  localparam logic [7:0] a_pin[3] = '{`ADDR_G_PIN, `ADDR_L_PIN, `ADDR_M_PIN};
  localparam logic [7:0] a_pnd[3] = '{8'h00, `ADDR_L_WAKE_PEND,
    `ADDR_M_WAKE_PEND};
  localparam logic [7:0] msk[3] = '{8'h7F, 8'hFF, 8'hFF};
  localparam int alt_p[7] = '{0, 0, 0, 0, 1, 1, 2};
  localparam int alt_b[7] = '{4, 5, 3, 1, 2, 1, 5};
  localparam logic [7:0] pw[3] = '{8'h80, 8'h41, 8'hC2};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic osc = 1'b0;
  logic [6:0] alt_en = 7'h00;
  logic [6:0] alt_val = 7'h00;
  logic spi_en = 1'b0;
  logic spi_mst = 1'b0;
  logic [3:0] spi_val = 4'h0;
  logic can_wake = 1'b0;
  logic [7:0] ext_val[3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] ed[3];
  logic [7:0] r;
  wire [7:0] rdata;
  wire [7:0] pin_in[3];
  wire [7:0] pad_out[3];
  wire [7:0] pad_oe[3];
  wire [7:0] pad_pu[3];
  wire halt, idle, phase, dly, irq;
  int seed = 32'hd75dd855;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int mcfg[3] = '{0, 0, 0};
  int mdat[3] = '{0, 0, 0};

  gpio_port_config_wakeup dut_u (
    .CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr), .WR_EN_IN(wr_en),
    .RD_EN_IN(rd_en), .WDATA_IN(wdata), .RDATA_OUT(rdata),
    .PORT_G_IN(pin_in[0]), .PORT_G_OUT(pad_out[0]),
    .PORT_G_OE_OUT(pad_oe[0]), .PORT_G_PULLUP_OUT(pad_pu[0]),
    .PORT_L_IN(pin_in[1]), .PORT_L_OUT(pad_out[1]),
    .PORT_L_OE_OUT(pad_oe[1]), .PORT_L_PULLUP_OUT(pad_pu[1]),
    .PORT_M_IN(pin_in[2]), .PORT_M_OUT(pad_out[2]),
    .PORT_M_OE_OUT(pad_oe[2]), .PORT_M_PULLUP_OUT(pad_pu[2]),
    .OSC_CLK_IN(osc),
    .SERIAL_DATA_OUT_EN_IN(alt_en[0]), .SERIAL_DATA_OUT_VAL_IN(alt_val[0]),
    .SERIAL_CLOCK_LINE_EN_IN(alt_en[1]),
    .SERIAL_CLOCK_LINE_VAL_IN(alt_val[1]),
    .TIMER1_IO_PIN_EN_IN(alt_en[2]), .TIMER1_IO_PIN_VAL_IN(alt_val[2]),
    .SUPERVISOR_EN_IN(alt_en[3]), .SUPERVISOR_VAL_IN(alt_val[3]),
    .USART_TRANSMIT_PIN_EN_IN(alt_en[4]),
    .USART_TRANSMIT_PIN_VAL_IN(alt_val[4]),
    .USART_CLOCK_PIN_EN_IN(alt_en[5]), .USART_CLOCK_PIN_VAL_IN(alt_val[5]),
    .SPI_EN_IN(spi_en), .SPI_MASTER_IN(spi_mst), .SPI_DRIVE_VAL_IN(spi_val),
    .TIMER2_B_PIN_EN_IN(alt_en[6]), .TIMER2_B_PIN_VAL_IN(alt_val[6]),
    .CAN_WAKE_IN(can_wake), .HALT_REQ_OUT(halt), .IDLE_REQ_OUT(idle),
    .SERIAL_ALT_PHASE_OUT(phase), .CLOCK_OUTPUT_DELAY_SELECT_OUT(dly),
    .MULTI_INPUT_WAKEUP_IRQ_OUT(irq), .EXTERNAL_IRQ_PIN_OUT(),
    .TIMER1_CAPTURE_OUT(), .SERIAL_DATA_IN_OUT(), .TIMER1_IO_PIN_OUT(),
    .USART_RECEIVE_PIN_OUT(), .USART_CLOCK_PIN_OUT(),
    .SPI_PIN_LEVEL_OUT(), .TIMER2_B_PIN_OUT()
  );

  for (genvar p = 0; p < 3; p++) begin : g_pins
    pin_board pins_u (.oe_in(pad_oe[p]), .drive_in(pad_out[p]),
      .ext_val_in(ext_val[p]), .level_out(pin_in[p]));
  end

  always #5 clk = ~clk;
  always @(posedge clk) #1 osc = ~osc;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    tick(1);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    tick(1);
    addr = a;
    rd_en = 1'b1;
    tick(1);
    rd_en = 1'b0;
    d = rdata;
  endtask

  // ------------------------------------------------------------
  // Pad model: register mode, then special, alternate and SPI use
  // ------------------------------------------------------------
  task automatic check_pads();
    logic [7:0] o;
    logic [7:0] d;
    logic [7:0] u;
    for (int p = 0; p < 3; p++) begin
      o = mcfg[p][7:0];
      d = mdat[p][7:0];
      if (p == 0) begin
        o = {2'b10, o[5:0]};
        d[7:6] = 2'b00;
      end
      u = ~o & d;
      for (int k = 0; k < 7; k++) begin
        if (alt_en[k] && alt_p[k] == p) begin
          o[alt_b[k]] = 1'b1;
          d[alt_b[k]] = alt_val[k];
          u[alt_b[k]] = 1'b0;
        end
      end
      if (p == 2 && spi_en) begin
        o[3:0] = spi_mst ? `SPI_OE_MASTER : `SPI_OE_SLAVE;
        d[3:0] = spi_val;
        u[3:0] = 4'h0;
      end
      ed[p] = (d & o) | (ext_val[p] & ~o);
      cmp("pad enable", o, pad_oe[p]);
      cmp("pad value", d & o & msk[p], pad_out[p] & o & msk[p]);
      cmp("pull up", u, pad_pu[p]);
    end
  endtask

  task automatic readback();
    for (int p = 0; p < 3; p++) begin
      rd(a_cfg[p], r);
      cmp("config reg", mcfg[p][7:0], r);
      rd(a_dat[p], r);
      cmp("data reg", mdat[p][7:0], r);
      rd(a_pin[p], r);
      cmp("pin levels", ed[p] & msk[p], r & msk[p]);
    end
  endtask

  initial begin
    tick(3);
    rst_b = 1'b1;
    tick(2);
    check_pads();
    wr(8'h3C, 8'hA5);
    wr(`ADDR_L_PIN, 8'hFF);
    readback();
    rd(8'h3C, r);
    cmp("unmapped read", 8'h00, r);
    $display("test reset done");
    repeat (6) begin
      for (int p = 0; p < 3; p++) begin
        mcfg[p] = $random(seed) & 255;
        mdat[p] = $random(seed) & 255;
        ext_val[p] = 8'($random(seed));
        wr(a_cfg[p], mcfg[p][7:0]);
        wr(a_dat[p], mdat[p][7:0]);
        if (p == 0) mdat[0] = mdat[0] & 8'h3F;
      end
      tick(2);
      check_pads();
      readback();
    end
    $display("test modes done");
    for (int k = 0; k < 7; k++) begin
      alt_en = 7'h01 << k;
      alt_val = 7'($random(seed));
      tick(2);
      check_pads();
    end
    alt_en = 7'h00;
    for (int m = 0; m < 2; m++) begin
      spi_en = 1'b1;
      spi_mst = m[0];
      spi_val = 4'($random(seed));
      tick(2);
      check_pads();
      spi_en = 1'b0;
      tick(2);
      check_pads();
    end
    $display("test alternate done");
    foreach (pw[i]) begin
      wr(`ADDR_G_DATA, pw[i]);
      cmp("power request", {6'h0, pw[i][7:6]}, {6'h0, halt, idle});
      tick(1);
      cmp("power release", 8'h00, {6'h0, halt, idle});
      mdat[0] = pw[i] & 8'h3F;
    end
    for (int v = 0; v < 4; v++) begin
      mcfg[0] = {v[1:0], mcfg[0][5:0]};
      wr(`ADDR_G_CFG, mcfg[0][7:0]);
      tick(1);
      cmp("special config", {6'h0, v[1:0]}, {6'h0, dly, phase});
    end
    tick(2);
    check_pads();
    readback();
    $display("test special port done");
    for (int p = 1; p < 3; p++) begin
      mcfg[p] = 0;
      mdat[p] = 0;
      ext_val[p] = 8'h00;
      wr(a_cfg[p], 8'h00);
      wr(a_dat[p], 8'h00);
    end
    wr(`ADDR_L_WAKE_EN, 8'hFF);
    wr(`ADDR_M_WAKE_EN, 8'hFF);
    wr(`ADDR_L_WAKE_PEND, 8'hFF);
    wr(`ADDR_M_WAKE_PEND, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      ext_val[1 + i / 8][i % 8] = 1'b1;
      tick(3);
      cmp("wake irq", 8'h01, {7'h0, irq});
      rd(a_pnd[1 + i / 8], r);
      cmp("wake pending", 8'h01 << (i % 8), r);
      wr(a_pnd[1 + i / 8], 8'h01 << (i % 8));
      ext_val[1 + i / 8][i % 8] = 1'b0;
      tick(3);
      cmp("wake cleared", 8'h00, {7'h0, irq});
    end
    wr(`ADDR_M_ALT_WAKE, 8'h80);
    ext_val[2][7] = 1'b1;
    tick(3);
    rd(`ADDR_M_WAKE_PEND, r);
    cmp("masked wake", 8'h00, r);
    rd(`ADDR_M_PIN, r);
    cmp("masked pin", 8'h80, r);
    can_wake = 1'b1;
    tick(3);
    rd(`ADDR_M_WAKE_PEND, r);
    cmp("can wake", 8'h80, r);
    $display("test wakeup done");
    print_verdict();
  end
endmodule

`default_nettype wire
